// >>> core/lp3_consts.vh
// Purpose: Constants for the loop three counter and overhead block.
// Assumes: 8-bit host port, 125 MHz ref_clk.
// Notes: Offsets are host byte addresses.
`ifndef LP3_CONSTS_VH
`define LP3_CONSTS_VH

////////////////////////////////////////////////////////////////////////
// Register offsets.
`define LP3_ADDR_PATCNT_HI 8'h7a
`define LP3_ADDR_PATCNT_LO 8'h7b
`define LP3_ADDR_RESTART 8'h7c
`define LP3_ADDR_REVISION 8'h7d
`define LP3_ADDR_MUX_TEST 8'h7e
`define LP3_ADDR_DMX_TEST 8'h7f

////////////////////////////////////////////////////////////////////////
// Reset values and field positions.
`define LP3_RST_BYTE 8'h00
`define LP3_RST_COUNT 16'h0000
`define LP3_COUNT_MAX 16'hffff
`define LP3_REV_MAJOR_MSB 7
`define LP3_REV_MAJOR_LSB 4
`define LP3_REV_MINOR_MSB 3
`define LP3_REV_MINOR_LSB 0

////////////////////////////////////////////////////////////////////////
// Frame layout.
`define LP3_IDLE_CODE 8'hff
`define LP3_CRC_POLY 6'h03
`define LP3_CRC_INIT 6'h00
`define LP3_LOOP_ID_ZBITS 6'h03
`define LP3_ZBITS_TOTAL 6'h30
`define LP3_EOC_BITS 6'h0d
`define LP3_UIB_BITS 6'h02
`define LP3_KIND_Z 2'h0
`define LP3_KIND_EOC 2'h1
`define LP3_KIND_UIB 2'h2

////////////////////////////////////////////////////////////////////////
// Timing.
`define LP3_CLK_PERIOD_NS 8
`define LP3_FRAME_TIME_NS 6000000
`define LP3_FRAME_CYCLES (`LP3_FRAME_TIME_NS / `LP3_CLK_PERIOD_NS)

`endif

// >>> core/lp3_counters.v
// Purpose: Loop three diagnostic registers, framing mode, CRC-6 and
//   user overhead channel.
// Assumes: Host strobes and line events are synchronous to ref_clk.
// Notes: Read data appears one cycle after the read strobe.
//
// Overview of operation
// - Sixteen-bit count of pattern errors.
// - High byte read latches count, clears counter.
// - No counting while pattern sync lost.
// - No saturation; overflow sets latched status bit.
// - Eight-bit mux restart count, zero after reset.
// - Read-only revision, major high, minor low.
// - Two read/write test registers, reset zero.
// - Unframed means point-to-point only.
// - Fractional fills unassigned channels with idle.
// - Fractional only allowed in framed mode.
// - CRC-6 excludes stuffing bits while first user indicator bit is clear.
// - First user indicator bit selects old CRC.
// - Three Z-bits loop id, rest user.
// - Non-compliant mode adds eoc and uib bits.
// - Frame-rate interrupt pulse for the host.
`include "lp3_consts.vh"

module lp3_counters #(
  // Revision code; the value is arbitrary.
  parameter [3:0] REV_MAJOR = 4'h2,
  parameter [3:0] REV_MINOR = 4'h0,
  parameter FRAME_CYCLES = `LP3_FRAME_CYCLES
) (
  // Clock and reset.
  input wire ref_clk,
  input wire resetn,
  // Host register port.
  input wire [7:0] host_addr,
  input wire host_rd,
  input wire host_wr,
  input wire [7:0] host_wdata,
  output reg [7:0] host_rdata,
  // Test pattern receiver and mux events.
  input wire pattern_error,
  input wire pattern_sync_lost,
  input wire mux_restart,
  input wire overflow_clear,
  output reg pattern_overflow,
  // Framing mode.
  input wire framed_mode,
  input wire fractional_req,
  output wire multipoint_allowed,
  output wire fractional_active,
  // E1 time slots.
  input wire [31:0] slot_assigned,
  input wire slot_valid,
  input wire [4:0] slot_index,
  input wire [7:0] slot_data,
  output reg slot_out_valid,
  output reg [7:0] slot_out_data,
  // CRC-6 bit stream.
  input wire crc_frame_start,
  input wire crc_bit_valid,
  input wire crc_bit,
  input wire crc_is_stuff,
  input wire first_user_indicator_bit,
  output reg crc_done,
  output reg [5:0] crc_value,
  // Overhead bits.
  input wire ovh_valid,
  input wire [1:0] ovh_kind,
  input wire [5:0] ovh_index,
  input wire ovh_bit,
  input wire standards_compliant,
  output reg [2:0] loop_id,
  output reg user_rx_valid,
  output reg user_rx_bit,
  // Frame-rate interrupt.
  output reg frame_irq
);

  //////////////////////////////////////////////////////////////////////
  // Helper functions.

  // One CRC-6 step.
  function [5:0] lp3_crc_step;
    input [5:0] crc;
    input bit_in;
    reg fb;
    begin
      fb = crc[5] ^ bit_in;
      lp3_crc_step = {crc[4:0], 1'b0} ^ (fb ? `LP3_CRC_POLY : 6'h00);
    end
  endfunction

  // Marks overhead bits that belong to the user channel.
  function lp3_is_user;
    input [1:0] kind;
    input [5:0] idx;
    input compliant;
    begin
      case (kind)
        `LP3_KIND_Z: begin
          lp3_is_user = (idx >= `LP3_LOOP_ID_ZBITS) && (idx < `LP3_ZBITS_TOTAL);
        end
        `LP3_KIND_EOC: begin
          lp3_is_user = !compliant && (idx < `LP3_EOC_BITS);
        end
        `LP3_KIND_UIB: begin
          lp3_is_user = !compliant && (idx < `LP3_UIB_BITS);
        end
        default: begin
          lp3_is_user = 1'b0;
        end
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Address decode.

  // True when a strobe hits the given register offset.
  function lp3_hit;
    input strobe;
    input [7:0] addr;
    input [7:0] target;
    begin
      lp3_hit = strobe && (addr == target);
    end
  endfunction

  // Bits needed to count from zero up to n - 1.
  function integer lp3_width;
    input integer n;
    integer v;
    begin
      lp3_width = 1;
      v = n - 1;
      while (v > 1) begin
        v = v >> 1;
        lp3_width = lp3_width + 1;
      end
    end
  endfunction

  wire rd_hi = lp3_hit(host_rd, host_addr, `LP3_ADDR_PATCNT_HI);
  wire wr_mux = lp3_hit(host_wr, host_addr, `LP3_ADDR_MUX_TEST);
  wire wr_dmx = lp3_hit(host_wr, host_addr, `LP3_ADDR_DMX_TEST);

  //////////////////////////////////////////////////////////////////////
  // Pattern error counter.

  reg [15:0] pat_count_q;
  reg [7:0] pat_low_hold_q;
  wire pat_inc = pattern_error && !pattern_sync_lost;
  wire pat_wrap = pat_inc && (pat_count_q == `LP3_COUNT_MAX);

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pat_count_q <= `LP3_RST_COUNT;
      pat_low_hold_q <= `LP3_RST_BYTE;
    end else begin
      if (rd_hi) begin
        pat_low_hold_q <= pat_count_q[7:0];
        pat_count_q <= pat_inc ? 16'h0001 : `LP3_RST_COUNT;
      end else if (pat_inc) begin
        pat_count_q <= pat_count_q + 16'h0001;
      end
    end
  end

  // Overflow flag; a new overflow wins over the clear.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pattern_overflow <= 1'b0;
    end else if (pat_wrap && !rd_hi) begin
      pattern_overflow <= 1'b1;
    end else if (overflow_clear) begin
      pattern_overflow <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Mux restart counter and test registers.

  reg [7:0] restart_q;
  reg [7:0] mux_test_q;
  reg [7:0] dmx_test_q;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      restart_q <= `LP3_RST_BYTE;
      mux_test_q <= `LP3_RST_BYTE;
      dmx_test_q <= `LP3_RST_BYTE;
    end else begin
      if (mux_restart) begin
        restart_q <= restart_q + 8'h01;
      end
      if (wr_mux) begin
        mux_test_q <= host_wdata;
      end
      if (wr_dmx) begin
        dmx_test_q <= host_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read data.

  reg [7:0] rdata_d;

  always @* begin
    case (host_addr)
      `LP3_ADDR_PATCNT_HI: begin
        rdata_d = pat_count_q[15:8];
      end
      `LP3_ADDR_PATCNT_LO: begin
        rdata_d = pat_low_hold_q;
      end
      `LP3_ADDR_RESTART: begin
        rdata_d = restart_q;
      end
      `LP3_ADDR_REVISION: begin
        rdata_d = {REV_MAJOR, REV_MINOR};
      end
      `LP3_ADDR_MUX_TEST: begin
        rdata_d = mux_test_q;
      end
      `LP3_ADDR_DMX_TEST: begin
        rdata_d = dmx_test_q;
      end
      default: begin
        rdata_d = `LP3_RST_BYTE;
      end
    endcase
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      host_rdata <= `LP3_RST_BYTE;
    end else if (host_rd) begin
      host_rdata <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Framing mode and idle fill.

  assign multipoint_allowed = framed_mode;
  assign fractional_active = fractional_req && framed_mode;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      slot_out_valid <= 1'b0;
      slot_out_data <= `LP3_RST_BYTE;
    end else begin
      slot_out_valid <= slot_valid;
      if (slot_valid) begin
        if (fractional_active && !slot_assigned[slot_index]) begin
          slot_out_data <= `LP3_IDLE_CODE;
        end else begin
          slot_out_data <= slot_data;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // CRC-6 over one frame.

  reg [5:0] crc_q;
  reg crc_run_q;
  wire crc_take = crc_bit_valid && (!crc_is_stuff || first_user_indicator_bit);

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      crc_q <= `LP3_CRC_INIT;
      crc_run_q <= 1'b0;
      crc_done <= 1'b0;
      crc_value <= `LP3_CRC_INIT;
    end else begin
      crc_done <= 1'b0;
      if (crc_frame_start) begin
        if (crc_run_q) begin
          crc_value <= crc_q;
          crc_done <= 1'b1;
        end
        crc_run_q <= 1'b1;
        crc_q <= crc_take ? lp3_crc_step(`LP3_CRC_INIT, crc_bit) : `LP3_CRC_INIT;
      end else if (crc_take) begin
        crc_q <= lp3_crc_step(crc_q, crc_bit);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Overhead bits: loop id and user channel.

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      loop_id <= 3'h0;
      user_rx_valid <= 1'b0;
      user_rx_bit <= 1'b0;
    end else begin
      user_rx_valid <= 1'b0;
      if (ovh_valid) begin
        if (ovh_kind == `LP3_KIND_Z && ovh_index < `LP3_LOOP_ID_ZBITS) begin
          loop_id[ovh_index[1:0]] <= ovh_bit;
        end
        if (lp3_is_user(ovh_kind, ovh_index, standards_compliant)) begin
          user_rx_valid <= 1'b1;
          user_rx_bit <= ovh_bit;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Frame-rate interrupt.

  // The divider is only as wide as the frame length needs.
  localparam FRAME_W = lp3_width(FRAME_CYCLES);
  localparam [31:0] FRAME_LAST_W = FRAME_CYCLES - 1;
  localparam [31:0] FRAME_ONE_W = 32'h1;
  localparam [FRAME_W-1:0] FRAME_LAST = FRAME_LAST_W[FRAME_W-1:0];
  localparam [FRAME_W-1:0] FRAME_ONE = FRAME_ONE_W[FRAME_W-1:0];

  reg [FRAME_W-1:0] frame_cnt_q;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      frame_cnt_q <= {FRAME_W{1'b0}};
      frame_irq <= 1'b0;
    end else begin
      frame_irq <= 1'b0;
      if (crc_frame_start || frame_cnt_q == FRAME_LAST) begin
        frame_cnt_q <= {FRAME_W{1'b0}};
        frame_irq <= 1'b1;
      end else begin
        frame_cnt_q <= frame_cnt_q + FRAME_ONE;
      end
    end
  end

endmodule

// >>> test/loop3_test_counters_and_overhead_tb_top.sv
// Purpose: Self-checking bench for lp3_counters.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Short frame count of 50 cycles.
module loop3_test_counters_and_overhead_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, resetn = 1'b0, host_rd = 1'b0, host_wr = 1'b0, overflow_clear = 1'b0;
  logic framed_mode = 1'b1, fractional_req = 1'b0, slot_valid = 1'b0, crc_frame_start = 1'b0;
  logic ovh_valid = 1'b0, ovh_bit = 1'b0, standards_compliant = 1'b1;
  logic crc_bit_valid = 1'b0, crc_bit = 1'b0, crc_is_stuff = 1'b0, first_user_indicator_bit = 1'b0;
  logic crc_done, slot_out_valid;
  logic [5:0] crc_value;
  logic [7:0] host_addr = 8'h00, host_wdata = 8'h00, slot_data = 8'h00, host_rdata, slot_out_data;
  logic [31:0] slot_assigned = 32'h00000020;
  logic [4:0] slot_index = 5'h00;
  logic [1:0] ovh_kind = 2'h0;
  logic [5:0] ovh_index = 6'h00;
  logic [2:0] loop_id;
  logic pattern_error, pattern_sync_lost, mux_restart, pattern_overflow, multipoint_allowed;
  logic fractional_active, user_rx_valid, user_rx_bit, frame_irq;
  int fail_count = 0, checks = 0;
  `define chk(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
  lp3_counters #(.FRAME_CYCLES(50)) dut (.*);
  lp3_line_model lm (.ref_clk(ref_clk), .pattern_error(pattern_error), .pattern_sync_lost(pattern_sync_lost),
    .mux_restart(mux_restart));
  always #4 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////
  // Host, slot and overhead transfers.
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    #1 host_rd = 1'b1;
    host_addr = a;
    @(posedge ref_clk);
    #1 host_rd = 1'b0;
    `chk(host_rdata, e)
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 host_wr = 1'b1;
    host_addr = a;
    host_wdata = d;
    @(posedge ref_clk);
    #1 host_wr = 1'b0;
  endtask
  task slot(input logic [4:0] i, input logic [7:0] d, input logic [7:0] e);
    @(posedge ref_clk);
    #1 slot_valid = 1'b1;
    slot_index = i;
    slot_data = d;
    @(posedge ref_clk);
    #1 slot_valid = 1'b0;
    `chk(slot_out_data, e)
    `chk(slot_out_valid, 1'b1)
  endtask
  task ovh(input logic [1:0] k, input logic [5:0] i, input logic b, input logic v);
    @(posedge ref_clk);
    #1 ovh_valid = 1'b1;
    ovh_kind = k;
    ovh_index = i;
    ovh_bit = b;
    @(posedge ref_clk);
    #1 ovh_valid = 1'b0;
    `chk(user_rx_valid, v)
  endtask
  task crcb(input logic s, input logic v, input logic b, input logic st);
    @(posedge ref_clk);
    #1 crc_frame_start = s;
    crc_bit_valid = v;
    crc_bit = b;
    crc_is_stuff = st;
  endtask
  task complete_run;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Test sequence.
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 resetn = 1'b1;
    rd(8'h7a, 8'h00); rd(8'h7b, 8'h00); rd(8'h7c, 8'h00);
    rd(8'h7d, 8'h20); rd(8'h7e, 8'h00); rd(8'h7f, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'h7e, 8'h5a); rd(8'h7e, 8'h5a); wr(8'h7f, 8'ha5); rd(8'h7f, 8'ha5);
    wr(8'h7d, 8'h00); rd(8'h7d, 8'h20);
    lm.burst(3, 1'b0);
    lm.burst(2, 1'b1);
    rd(8'h7b, 8'h00);
    rd(8'h7a, 8'h00); rd(8'h7b, 8'h03);
    rd(8'h7a, 8'h00); rd(8'h7b, 8'h00);
    lm.burst(300, 1'b0);
    rd(8'h7a, 8'h01); rd(8'h7b, 8'h2c);
    lm.burst(65537, 1'b0);
    rd(8'h7a, 8'h00); rd(8'h7b, 8'h01);
    `chk(pattern_overflow, 1'b1)
    @(posedge ref_clk);
    #1 overflow_clear = 1'b1;
    @(posedge ref_clk);
    #1 overflow_clear = 1'b0;
    `chk(pattern_overflow, 1'b0)
    lm.restarts(3);
    rd(8'h7c, 8'h03);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      #1 {framed_mode, fractional_req} = i[1:0];
      #1 `chk(multipoint_allowed, i[1])
      `chk(fractional_active, &i[1:0])
    end
    slot(5'h04, 8'h3c, 8'hff); slot(5'h05, 8'h3c, 8'h3c);
    fractional_req = 1'b0;
    slot(5'h04, 8'h3c, 8'h3c);
    {framed_mode, fractional_req} = 2'h1;
    slot(5'h04, 8'h3c, 8'h3c);
    ovh(2'h0, 6'h01, 1'b1, 1'b0);
    `chk(loop_id, 3'h2)
    ovh(2'h0, 6'h2f, 1'b1, 1'b1); ovh(2'h1, 6'h0c, 1'b0, 1'b0);
    standards_compliant = 1'b0;
    ovh(2'h1, 6'h0c, 1'b0, 1'b1);
    `chk(user_rx_bit, 1'b0)
    ovh(2'h2, 6'h01, 1'b1, 1'b1);
    `chk(user_rx_bit, 1'b1)
    crcb(1'b1, 1'b0, 1'b0, 1'b0); crcb(1'b0, 1'b0, 1'b0, 1'b0);
    `chk(frame_irq, 1'b1)
    repeat (49) @(posedge ref_clk);
    #1 `chk(frame_irq, 1'b0)
    @(posedge ref_clk);
    #1 `chk(frame_irq, 1'b1)
    for (int u = 0; u < 2; u++) begin
      first_user_indicator_bit = u[0];
      crcb(1'b1, 1'b1, 1'b1, 1'b0); crcb(1'b0, 1'b1, 1'b1, 1'b1); crcb(1'b0, 1'b1, 1'b1, 1'b0);
      crcb(1'b1, 1'b0, 1'b0, 1'b0); crcb(1'b0, 1'b0, 1'b0, 1'b0);
      `chk(crc_done, 1'b1)
      `chk(crc_value, u[0] ? 6'h09 : 6'h05)
      crcb(1'b0, 1'b0, 1'b0, 1'b0);
      `chk(crc_done, 1'b0)
    end
    @(posedge ref_clk);
    #1 resetn = 1'b0;
    @(posedge ref_clk);
    #1 resetn = 1'b1;
    rd(8'h7e, 8'h00);
    rd(8'h7c, 8'h00);
    complete_run;
  end
  initial begin
    #750000;
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    complete_run;
  end
endmodule

// >>> test/lp3_counters_props.sv
// Purpose: Port checks for lp3_counters.
// Assumes: One clock domain, resetn asynchronous and active low.
// Notes: Bound to every instance of the block.
module lp3_props #(parameter [3:0] REV_MAJOR = 4'h2, parameter [3:0] REV_MINOR = 4'h0) (
  // Clock, reset and host port.
  input wire ref_clk, input wire resetn, input wire [7:0] host_addr, input wire host_rd,
  input wire host_wr, input wire [7:0] host_wdata, input wire [7:0] host_rdata,
  // Status, framing and slots.
  input wire overflow_clear, input wire pattern_overflow, input wire framed_mode, input wire fractional_req,
  input wire multipoint_allowed, input wire fractional_active, input wire [31:0] slot_assigned,
  input wire slot_valid, input wire [4:0] slot_index, input wire [7:0] slot_out_data,
  // Frame timing and overhead.
  input wire crc_frame_start, input wire frame_irq, input wire standards_compliant, input wire ovh_valid,
  input wire [1:0] ovh_kind, input wire [5:0] ovh_index, input wire user_rx_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_mp; multipoint_allowed == framed_mode; endproperty
  a_mp: assert property (p_mp) else $error("multipoint flag wrong");
  property p_frac; fractional_active == (fractional_req && framed_mode); endproperty
  a_frac: assert property (p_frac) else $error("fractional flag wrong");
  property p_idle; slot_valid && fractional_active && !slot_assigned[slot_index] |=> slot_out_data == 8'hff; endproperty
  a_idle: assert property (p_idle) else $error("idle code missing");
  property p_rev; host_rd && host_addr == 8'h7d |=> host_rdata == {REV_MAJOR, REV_MINOR}; endproperty
  a_rev: assert property (p_rev) else $error("revision wrong");
  property p_ovf; pattern_overflow && !overflow_clear |=> pattern_overflow; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow dropped");
  property p_zu; ovh_valid && ovh_kind == 2'h0 && ovh_index > 6'h02 && ovh_index < 6'h30 |=> user_rx_valid; endproperty
  a_zu: assert property (p_zu) else $error("user bit lost");
  property p_zid; ovh_valid && ovh_kind == 2'h0 && ovh_index < 6'h03 |=> !user_rx_valid; endproperty
  a_zid: assert property (p_zid) else $error("id bit in user channel");
  property p_eoc; ovh_valid && ovh_kind == 2'h1 && ovh_index < 6'h0d |=> user_rx_valid == !$past(standards_compliant); endproperty
  a_eoc: assert property (p_eoc) else $error("eoc routing wrong");
  property p_irq; crc_frame_start |-> ##[1:2] frame_irq; endproperty
  a_irq: assert property (p_irq) else $error("frame pulse missing");
  property p_tst; host_wr && host_addr == 8'h7e ##2 host_rd && !host_wr && host_addr == 8'h7e
    |=> host_rdata == $past(host_wdata, 3); endproperty
  a_tst: assert property (p_tst) else $error("test register lost data");
endmodule
bind lp3_counters lp3_props #(.REV_MAJOR(REV_MAJOR), .REV_MINOR(REV_MINOR)) u_props (
  .ref_clk(ref_clk), .resetn(resetn), .host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr),
  .host_wdata(host_wdata), .host_rdata(host_rdata), .overflow_clear(overflow_clear),
  .pattern_overflow(pattern_overflow), .framed_mode(framed_mode), .fractional_req(fractional_req),
  .multipoint_allowed(multipoint_allowed), .fractional_active(fractional_active),
  .slot_assigned(slot_assigned), .slot_valid(slot_valid), .slot_index(slot_index),
  .slot_out_data(slot_out_data), .crc_frame_start(crc_frame_start), .frame_irq(frame_irq),
  .standards_compliant(standards_compliant), .ovh_valid(ovh_valid), .ovh_kind(ovh_kind),
  .ovh_index(ovh_index), .user_rx_valid(user_rx_valid)
);

// >>> test/lp3_line_model.sv
// Purpose: Line-side model of the pattern receiver and mux loop.
// Assumes: Events are sampled on the rising ref_clk.
// Notes: Drives 1 ns after each rising edge.
module lp3_line_model (
  // Clock and events.
  input wire ref_clk, output logic pattern_error, output logic pattern_sync_lost, output logic mux_restart
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pattern_error = 1'b0;
    pattern_sync_lost = 1'b0;
    mux_restart = 1'b0;
  end
  // One error per cycle for n cycles, sync optionally lost.
  task burst(input int n, input logic lost);
    @(posedge ref_clk);
    #1 pattern_error = 1'b1;
    pattern_sync_lost = lost;
    repeat (n) @(posedge ref_clk);
    #1 pattern_error = 1'b0;
    pattern_sync_lost = 1'b0;
  endtask
  task restarts(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1 mux_restart = 1'b1;
      @(posedge ref_clk);
      #1 mux_restart = 1'b0;
    end
  endtask
endmodule
